// ==== bmrf_datapath_model.sv ====
// Purpose: datapath side issuing requests to the register file
// Assumes: tasks called from the bench, one at a time
// Notes: each request stands one cycle, then lines go idle
`timescale 1ns/1ps
module bmrf_datapath_model (
	// clock and status
	input wire logic core_clk,
	input wire logic [31:0] liveStatusWord,
	// requests
	output bmrf_pkg::bmrf_wr_t wrReq,
	output bmrf_pkg::bmrf_psw_t pswReq,
	output bmrf_pkg::bmrf_exc_t excReq,
	output logic excReturn
);
	import bmrf_pkg::*;
	initial begin
		wrReq = '0;
		pswReq = '0;
		excReq = '0;
		excReturn = 1'b0;
	end
	task automatic idle();
		@(posedge core_clk);
		wrReq <= '0;
		pswReq <= '0;
		excReq <= '0;
		excReturn <= 1'b0;
		#1;
	endtask
	// f is {setFlags, nzcv, satSet, geValid}; lane flags reuse nzcv
	task automatic wr(input logic [3:0] c, i, input logic [31:0] d, input logic [6:0] f);
		@(posedge core_clk);
		wrReq <= {1'b1, c, i, d, f[6:1], f[0], f[5:2]};
		idle();
	endtask
	task automatic psw(input logic [31:0] d);
		@(posedge core_clk);
		// reserved bits go back as they were read
		pswReq <= {1'b1, (d & ~32'h00F00000) | (liveStatusWord & 32'h00F00000)};
		idle();
	endtask
	task automatic exc(input bmrf_exc_kind_t k, input logic [31:0] l, v);
		@(posedge core_clk);
		excReq <= {1'b1, k, l, v};
		idle();
	endtask
	task automatic ret();
		@(posedge core_clk);
		excReturn <= 1'b1;
		idle();
	endtask
endmodule // bmrf_datapath_model

// ==== bmrf_defines.svh ====
// Purpose: constants of the banked mode register file
// Assumes: included by bare name from the package and the module
// Notes: the level codes are the customary five-bit ones
`ifndef BMRF_DEFINES_SVH
`define BMRF_DEFINES_SVH

// ----------------------------------------
// level codes
// ----------------------------------------
`define BMRF_MODE_USR 5'h10
`define BMRF_MODE_FIQ 5'h11
`define BMRF_MODE_IRQ 5'h12
`define BMRF_MODE_SVC 5'h13
`define BMRF_MODE_ABT 5'h17
`define BMRF_MODE_UND 5'h1B
`define BMRF_MODE_SYS 5'h1F

// ----------------------------------------
// status word fields
// ----------------------------------------
`define BMRF_M_LO 0
`define BMRF_M_HI 4
`define BMRF_T 5
`define BMRF_F 6
`define BMRF_I 7
`define BMRF_A 8
`define BMRF_E 9
`define BMRF_ITL_LO 10
`define BMRF_ITL_HI 15
`define BMRF_SIMD_LO 16
`define BMRF_SIMD_HI 19
`define BMRF_J 24
`define BMRF_ITH_LO 25
`define BMRF_ITH_HI 26
`define BMRF_Q 27
`define BMRF_V 28
`define BMRF_N 31
`define BMRF_RSV_MASK 32'h00F00000
`define BMRF_USER_PROT_MASK 32'h000001DF
`define BMRF_STATUS_RST 32'h000001D3

// ----------------------------------------
// register indices and bank slots
// ----------------------------------------
`define BMRF_IDX_SHARED_LAST 4'h7
`define BMRF_IDX_HI_FIRST 4'h8
`define BMRF_IDX_STACK 4'hD
`define BMRF_IDX_LINK 4'hE
`define BMRF_IDX_IPTR 4'hF
`define BMRF_NUM_SHARED 8
`define BMRF_NUM_HI 5
`define BMRF_NUM_BANKS 6
`define BMRF_BANK_USR 3'h0
`define BMRF_BANK_FIQ 3'h1
`define BMRF_BANK_IRQ 3'h2
`define BMRF_BANK_SVC 3'h3
`define BMRF_BANK_ABT 3'h4
`define BMRF_BANK_UND 3'h5
`define BMRF_COND_ALWAYS 3'h7
`define BMRF_COND_ZERO 3'h0
`define BMRF_COND_CARRY 3'h1
`define BMRF_COND_NEG 3'h2
`define BMRF_COND_OVF 3'h3
`define BMRF_COND_HIGHER 3'h4
`define BMRF_COND_NOLESS 3'h5
`define BMRF_COND_GREATER 3'h6

`endif

// ==== bmrf_pkg.sv ====
// Purpose: types of the banked mode register file
// Assumes: bmrf_defines.svh on the include path
// Notes: none
`include "bmrf_defines.svh"

package bmrf_pkg;

	typedef enum logic [4:0] {
		MODE_USR = 5'b10000,
		MODE_FIQ = 5'b10001,
		MODE_IRQ = 5'b10010,
		MODE_SVC = 5'b10011,
		MODE_ABT = 5'b10111,
		MODE_UND = 5'b11011,
		MODE_SYS = 5'b11111
	} bmrf_mode_t;

	typedef enum logic [2:0] {
		EXC_SVC = 3'b000,
		EXC_FIQ = 3'b001,
		EXC_IRQ = 3'b010,
		EXC_PABT = 3'b011,
		EXC_DABT = 3'b100,
		EXC_UNDEF = 3'b101
	} bmrf_exc_kind_t;

	typedef struct packed {
		logic valid;
		logic [3:0] cond;
		logic [3:0] idx;
		logic [31:0] data;
		logic setFlags;
		logic [3:0] nzcv;
		logic satSet;
		logic geValid;
		logic [3:0] ge;
	} bmrf_wr_t;

	typedef struct packed {
		logic valid;
		logic [31:0] data;
	} bmrf_psw_t;

	typedef struct packed {
		logic valid;
		bmrf_exc_kind_t kind;
		logic [31:0] link;
		logic [31:0] vector;
	} bmrf_exc_t;

	typedef struct packed {
		logic [4:0] mode;
		logic compactIsa;
		logic bytecode;
		logic fiqBlocked;
		logic irqBlocked;
		logic abortHeld;
		logic bigEndian;
		logic [7:0] condBlockState;
		logic [3:0] simdCompareFlags;
		logic sat;
		logic [3:0] nzcv;
	} bmrf_ctl_t;

endpackage

// ==== bmrf_regfile.sv ====
// Purpose: banked general register file with live and saved status words
// Assumes: one request of each kind per cycle, inputs synchronous to core_clk
// Notes: reads are registered, one cycle after the index is presented
`timescale 1ns/1ps
`include "bmrf_defines.svh"

module bmrf_regfile (
	// clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// read ports
	input wire logic [3:0] rdIdxA,
	input wire logic [3:0] rdIdxB,
	output logic [31:0] rdDataA,
	output logic [31:0] rdDataB,
	// datapath write with flag results
	input wire bmrf_pkg::bmrf_wr_t wrReq,
	output logic condPass,
	// explicit status word write
	input wire bmrf_pkg::bmrf_psw_t pswReq,
	// exception entry and return
	input wire bmrf_pkg::bmrf_exc_t excReq,
	input wire logic excReturn,
	// status view
	output logic [31:0] liveStatusWord,
	output logic [31:0] savedStatusWord,
	output logic [31:0] instrPointer,
	output bmrf_pkg::bmrf_ctl_t ctl
);
	import bmrf_pkg::*;

	// ----------------------------------------
	// storage
	// ----------------------------------------
	logic [31:0] sharedFile_reg [`BMRF_NUM_SHARED];
	logic [31:0] hiFile_reg [`BMRF_NUM_HI];
	logic [31:0] fiqHiFile_reg [`BMRF_NUM_HI];
	logic [31:0] stackFile_reg [`BMRF_NUM_BANKS];
	logic [31:0] linkFile_reg [`BMRF_NUM_BANKS];
	// slot of the user bank stays zero: user and system have no saved word
	logic [31:0] savedFile_reg [`BMRF_NUM_BANKS];
	logic [31:0] iptr_reg;
	logic [31:0] live_reg;
	logic [31:0] live_next;
	logic [31:0] rdA_reg;
	logic [31:0] rdB_reg;

	// ----------------------------------------
	// functions
	// ----------------------------------------
	function automatic logic [2:0] bankOf(input logic [4:0] m);
		case (m)
			`BMRF_MODE_FIQ: bankOf = `BMRF_BANK_FIQ;
			`BMRF_MODE_IRQ: bankOf = `BMRF_BANK_IRQ;
			`BMRF_MODE_SVC: bankOf = `BMRF_BANK_SVC;
			`BMRF_MODE_ABT: bankOf = `BMRF_BANK_ABT;
			`BMRF_MODE_UND: bankOf = `BMRF_BANK_UND;
			default: bankOf = `BMRF_BANK_USR;
		endcase
	endfunction

	function automatic logic modeLegal(input logic [4:0] m);
		case (m)
			`BMRF_MODE_USR, `BMRF_MODE_FIQ, `BMRF_MODE_IRQ, `BMRF_MODE_SVC,
			`BMRF_MODE_ABT, `BMRF_MODE_UND, `BMRF_MODE_SYS: modeLegal = 1'b1;
			default: modeLegal = 1'b0;
		endcase
	endfunction

	function automatic logic [4:0] excTarget(input bmrf_exc_kind_t k);
		case (k)
			EXC_FIQ: excTarget = `BMRF_MODE_FIQ;
			EXC_IRQ: excTarget = `BMRF_MODE_IRQ;
			EXC_PABT, EXC_DABT: excTarget = `BMRF_MODE_ABT;
			EXC_UNDEF: excTarget = `BMRF_MODE_UND;
			default: excTarget = `BMRF_MODE_SVC;
		endcase
	endfunction

	function automatic logic [2:0] hiSlot(input logic [3:0] idx);
		logic [3:0] d;
		d = idx - `BMRF_IDX_HI_FIRST;
		hiSlot = d[2:0];
	endfunction

	// cond[3:1] picks the test, cond[0] inverts it except for the always pair
	function automatic logic condHolds(input logic [3:0] c, input logic [3:0] f);
		logic n;
		logic z;
		logic cy;
		logic v;
		logic base;
		{n, z, cy, v} = f;
		case (c[3:1])
			`BMRF_COND_ZERO: base = z;
			`BMRF_COND_CARRY: base = cy;
			`BMRF_COND_NEG: base = n;
			`BMRF_COND_OVF: base = v;
			`BMRF_COND_HIGHER: base = cy & ~z;
			`BMRF_COND_NOLESS: base = (n == v);
			`BMRF_COND_GREATER: base = ~z & (n == v);
			default: base = 1'b1;
		endcase
		condHolds = (c[3:1] == `BMRF_COND_ALWAYS) ? 1'b1 : (base ^ c[0]);
	endfunction

	function automatic logic [31:0] readReg(input logic [3:0] idx, input logic [2:0] bank);
		if (idx <= `BMRF_IDX_SHARED_LAST)
			readReg = sharedFile_reg[idx[2:0]];
		else if (idx == `BMRF_IDX_STACK)
			readReg = stackFile_reg[bank];
		else if (idx == `BMRF_IDX_LINK)
			readReg = linkFile_reg[bank];
		else if (idx == `BMRF_IDX_IPTR)
			readReg = iptr_reg;
		else if (bank == `BMRF_BANK_FIQ)
			readReg = fiqHiFile_reg[hiSlot(idx)];
		else
			readReg = hiFile_reg[hiSlot(idx)];
	endfunction

	// ----------------------------------------
	// decode
	// ----------------------------------------
	wire [4:0] curMode = live_reg[`BMRF_M_HI:`BMRF_M_LO];
	wire [2:0] curBank = bankOf(curMode);
	wire isUser = (curMode == `BMRF_MODE_USR);
	wire [3:0] curFlags = live_reg[`BMRF_N:`BMRF_V];
	wire [4:0] excMode = excTarget(excReq.kind);
	wire [2:0] excBank = bankOf(excMode);

	assign condPass = condHolds(wrReq.cond, curFlags);
	// an exception entry kills the instruction in flight
	wire wrGo = wrReq.valid & condPass & ~excReq.valid;
	wire retGo = excReturn & ~excReq.valid & (curBank != `BMRF_BANK_USR);

	wire wrShared = wrGo & (wrReq.idx <= `BMRF_IDX_SHARED_LAST);
	wire wrStack = wrGo & (wrReq.idx == `BMRF_IDX_STACK);
	wire wrLink = wrGo & (wrReq.idx == `BMRF_IDX_LINK);
	wire wrIptr = wrGo & (wrReq.idx == `BMRF_IDX_IPTR);
	wire wrHi = wrGo & ~wrShared & ~wrStack & ~wrLink & ~wrIptr;
	wire wrFiqHi = wrHi & (curBank == `BMRF_BANK_FIQ);

	// ----------------------------------------
	// status word next value
	// ----------------------------------------
	wire [31:0] protMask = isUser ? (`BMRF_USER_PROT_MASK | `BMRF_RSV_MASK)
		: `BMRF_RSV_MASK;
	wire [31:0] pswMerged = (live_reg & protMask) | (pswReq.data & ~protMask);
	// an illegal level code keeps the current level
	wire pswModeOk = modeLegal(pswMerged[`BMRF_M_HI:`BMRF_M_LO]);
	wire [31:0] pswFinal = pswModeOk ? pswMerged
		: {pswMerged[31:`BMRF_T], curMode};

	logic [31:0] entryWord;
	logic [31:0] flagWord;

	always_comb begin
		entryWord = live_reg;
		entryWord[`BMRF_M_HI:`BMRF_M_LO] = excMode;
		entryWord[`BMRF_T] = 1'b0;
		entryWord[`BMRF_J] = 1'b0;
		entryWord[`BMRF_ITL_HI:`BMRF_ITL_LO] = '0;
		entryWord[`BMRF_ITH_HI:`BMRF_ITH_LO] = '0;
		entryWord[`BMRF_I] = 1'b1;
		if (excReq.kind == EXC_FIQ)
			entryWord[`BMRF_F] = 1'b1;
		if ((excReq.kind != EXC_SVC) && (excReq.kind != EXC_UNDEF))
			entryWord[`BMRF_A] = 1'b1;
	end

	always_comb begin
		flagWord = live_reg;
		if (wrGo & wrReq.setFlags)
			flagWord[`BMRF_N:`BMRF_V] = wrReq.nzcv;
		if (wrGo & wrReq.geValid)
			flagWord[`BMRF_SIMD_HI:`BMRF_SIMD_LO] = wrReq.ge;
	end

	always_comb begin
		if (excReq.valid)
			live_next = entryWord;
		else if (retGo)
			live_next = savedFile_reg[curBank];
		else if (pswReq.valid)
			live_next = pswFinal;
		else
			live_next = flagWord;
		// saturation set wins over a clearing status write in the same cycle
		if (wrGo & wrReq.satSet & ~retGo)
			live_next[`BMRF_Q] = 1'b1;
		live_next = live_next & ~`BMRF_RSV_MASK;
	end

	// ----------------------------------------
	// state
	// ----------------------------------------
	// status word and read ports
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			live_reg <= `BMRF_STATUS_RST;
			rdA_reg <= '0;
			rdB_reg <= '0;
		end else begin
			live_reg <= live_next;
			rdA_reg <= readReg(rdIdxA, curBank);
			rdB_reg <= readReg(rdIdxB, curBank);
		end
	end

	// registers 0 to 7: one copy seen from every level
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			for (int i = 0; i < `BMRF_NUM_SHARED; i++)
				sharedFile_reg[i] <= '0;
		end else if (wrShared) begin
			sharedFile_reg[wrReq.idx[2:0]] <= wrReq.data;
		end
	end

	// registers 8 to 12: the quick interrupt level has a copy of its own
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			for (int i = 0; i < `BMRF_NUM_HI; i++) begin
				hiFile_reg[i] <= '0;
				fiqHiFile_reg[i] <= '0;
			end
		end else if (wrFiqHi) begin
			fiqHiFile_reg[hiSlot(wrReq.idx)] <= wrReq.data;
		end else if (wrHi) begin
			hiFile_reg[hiSlot(wrReq.idx)] <= wrReq.data;
		end
	end

	// stack slots: user and system share slot zero
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			for (int i = 0; i < `BMRF_NUM_BANKS; i++)
				stackFile_reg[i] <= '0;
		end else if (wrStack) begin
			stackFile_reg[curBank] <= wrReq.data;
		end
	end

	// link slots: entry and datapath never write together,
	// because an entry kills the datapath write in the same cycle
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			for (int i = 0; i < `BMRF_NUM_BANKS; i++)
				linkFile_reg[i] <= '0;
		end else if (excReq.valid) begin
			linkFile_reg[excBank] <= excReq.link;
		end else if (wrLink) begin
			linkFile_reg[curBank] <= wrReq.data;
		end
	end

	// saved words: only an exception entry fills them
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			for (int i = 0; i < `BMRF_NUM_BANKS; i++)
				savedFile_reg[i] <= '0;
		end else if (excReq.valid) begin
			savedFile_reg[excBank] <= live_reg;
		end
	end

	// pointer: no auto increment, the datapath or an exception entry's vector supplies every new value
	// so a fetch stage must write it back after each instruction
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			iptr_reg <= '0;
		end else if (excReq.valid) begin
			iptr_reg <= excReq.vector;
		end else if (wrIptr) begin
			iptr_reg <= wrReq.data;
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	assign rdDataA = rdA_reg;
	assign rdDataB = rdB_reg;
	assign liveStatusWord = live_reg;
	assign savedStatusWord = savedFile_reg[curBank];
	assign instrPointer = iptr_reg;
	assign ctl.mode = curMode;
	assign ctl.compactIsa = live_reg[`BMRF_T];
	assign ctl.bytecode = live_reg[`BMRF_J];
	assign ctl.fiqBlocked = live_reg[`BMRF_F];
	assign ctl.irqBlocked = live_reg[`BMRF_I];
	assign ctl.abortHeld = live_reg[`BMRF_A];
	assign ctl.bigEndian = live_reg[`BMRF_E];
	assign ctl.condBlockState = {live_reg[`BMRF_ITL_HI:`BMRF_ITL_LO],
		live_reg[`BMRF_ITH_HI:`BMRF_ITH_LO]};
	assign ctl.simdCompareFlags = live_reg[`BMRF_SIMD_HI:`BMRF_SIMD_LO];
	assign ctl.sat = live_reg[`BMRF_Q];
	assign ctl.nzcv = curFlags;

endmodule // bmrf_regfile

// ==== bmrf_regfile_props.sv ====
// Purpose: port checks of the banked register file
// Assumes: bound to bmrf_regfile
// Notes: one clock domain, so default clocking is used
`timescale 1ns/1ps
module bmrf_regfile_props (
	// clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// requests
	input wire bmrf_pkg::bmrf_wr_t wrReq,
	input wire logic condPass,
	input wire bmrf_pkg::bmrf_psw_t pswReq,
	input wire bmrf_pkg::bmrf_exc_t excReq,
	input wire logic excReturn,
	// status view
	input wire logic [31:0] liveStatusWord,
	input wire logic [31:0] savedStatusWord,
	input wire bmrf_pkg::bmrf_ctl_t ctl
);
	import bmrf_pkg::*;
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);
	wire logic quiet = !pswReq.valid && !excReq.valid && !excReturn;
	wire logic setf = wrReq.valid && wrReq.setFlags && condPass;
	property p_rst; $fell(rst) |-> liveStatusWord == 32'h000001D3; endproperty
	a_rst: assert property (p_rst) else $error("bad reset word");
	property p_rsv; liveStatusWord[23:20] == 4'h0 && ctl.mode == liveStatusWord[4:0]; endproperty
	a_rsv: assert property (p_rsv) else $error("reserved or level field");
	property p_view;
		ctl.condBlockState == {liveStatusWord[15:10], liveStatusWord[26:25]}
		&& ctl.simdCompareFlags == liveStatusWord[19:16];
	endproperty
	a_view: assert property (p_view) else $error("field view wrong");
	property p_legal;
		ctl.mode inside {MODE_USR, MODE_FIQ, MODE_IRQ, MODE_SVC, MODE_ABT, MODE_UND, MODE_SYS};
	endproperty
	a_legal: assert property (p_legal) else $error("illegal level");
	property p_setf; setf && quiet |=> ctl.nzcv == $past(wrReq.nzcv); endproperty
	a_setf: assert property (p_setf) else $error("flags not taken");
	property p_keep; !setf && quiet |=> $stable(ctl.nzcv); endproperty
	a_keep: assert property (p_keep) else $error("flags moved");
	property p_sticky; liveStatusWord[27] && quiet |=> liveStatusWord[27]; endproperty
	a_sticky: assert property (p_sticky) else $error("saturation lost");
	property p_irq;
		excReq.valid && excReq.kind == EXC_IRQ |=> ctl.mode == MODE_IRQ && ctl.irqBlocked
		&& savedStatusWord == $past(liveStatusWord);
	endproperty
	a_irq: assert property (p_irq) else $error("irq entry wrong");
	property p_fiq;
		excReq.valid && excReq.kind == EXC_FIQ |=> ctl.mode == MODE_FIQ && ctl.fiqBlocked;
	endproperty
	a_fiq: assert property (p_fiq) else $error("fiq entry wrong");
	property p_sys; excReq.valid |=> ctl.mode != MODE_SYS && !ctl.compactIsa; endproperty
	a_sys: assert property (p_sys) else $error("exception into system");
	property p_ret;
		excReturn && !excReq.valid && ctl.mode != MODE_USR && ctl.mode != MODE_SYS
		|=> liveStatusWord == $past(savedStatusWord);
	endproperty
	a_ret: assert property (p_ret) else $error("return not restored");
	property p_user;
		ctl.mode == MODE_USR && pswReq.valid && !excReq.valid
		|=> (liveStatusWord & 32'h000001DF) == ($past(liveStatusWord) & 32'h000001DF);
	endproperty
	a_user: assert property (p_user) else $error("user changed level");
	c_fiq: cover property (excReq.valid && excReq.kind == EXC_FIQ);
	c_ret: cover property (excReturn);
	c_user: cover property (ctl.mode == MODE_USR && pswReq.valid);
endmodule // bmrf_regfile_props

// ==== bmrf_regfile_test.sv ====
// Purpose: self-checking bench of the banked register file
// Assumes: datapath model drives requests, bench drives read indices
// Notes: expectations follow the level codes and field layout
`timescale 1ns/1ps
module bmrf_regfile_test;
	import bmrf_pkg::*;
	logic core_clk = 1'b0;
	logic rst = 1'b1;
	logic [3:0] rdIdxA = 4'h0;
	logic [3:0] rdIdxB = 4'h0;
	logic [31:0] rdDataA, rdDataB, liveStatusWord, savedStatusWord, instrPointer;
	logic condPass, excReturn;
	bmrf_wr_t wrReq;
	bmrf_psw_t pswReq;
	bmrf_exc_t excReq;
	bmrf_ctl_t ctl;
	int errors = 0;
	int n_checks = 0;
	int cycles = 0;
	always #12.5 core_clk = ~core_clk;
	bmrf_regfile i_dut (.core_clk, .rst, .rdIdxA, .rdIdxB, .rdDataA, .rdDataB, .wrReq,
		.condPass, .pswReq, .excReq, .excReturn, .liveStatusWord, .savedStatusWord,
		.instrPointer, .ctl);
	bmrf_datapath_model i_dp (.core_clk, .liveStatusWord, .wrReq, .pswReq, .excReq,
		.excReturn);
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 5000) begin
			errors++;
			report_and_stop();
		end
	end
	task automatic chk(input string n, input logic [31:0] s, e);
		n_checks++;
		if (s !== e) begin
			errors++;
			$display("MISMATCH %s exp %h seen %h", n, e, s);
		end
	endtask
	task automatic rd(input logic [3:0] a, b);
		@(posedge core_clk);
		rdIdxA <= a;
		rdIdxB <= b;
		@(posedge core_clk);
		#1;
	endtask
	task automatic t_bank();
		i_dp.wr(4'hE, 4'h0, 32'h11111111, 7'h00);
		i_dp.wr(4'hE, 4'hD, 32'h22222222, 7'h00);
		i_dp.wr(4'hE, 4'h8, 32'h44444444, 7'h00);
		i_dp.exc(EXC_IRQ, 32'h33333333, 32'h00000018);
		chk("mode", ctl.mode, MODE_IRQ);
		chk("saved", savedStatusWord, 32'h000001D3);
		chk("iptr", instrPointer, 32'h00000018);
		rd(4'h0, 4'hD);
		chk("r0", rdDataA, 32'h11111111);
		chk("r13", rdDataB, 32'h0);
		rd(4'hE, 4'hF);
		chk("r14", rdDataA, 32'h33333333);
		chk("r15", rdDataB, 32'h00000018);
		i_dp.ret();
		i_dp.exc(EXC_FIQ, 32'h0, 32'h0);
		rd(4'h8, 4'h0);
		chk("r8fiq", rdDataA, 32'h0);
		chk("r0fiq", rdDataB, 32'h11111111);
		i_dp.ret();
		chk("mode", ctl.mode, MODE_SVC);
		rd(4'hD, 4'h8);
		chk("r13svc", rdDataA, 32'h22222222);
		chk("r8svc", rdDataB, 32'h44444444);
		$display("test bank done");
	endtask
	task automatic t_kinds();
		bmrf_exc_kind_t k[6] = '{EXC_SVC, EXC_FIQ, EXC_IRQ, EXC_PABT, EXC_DABT, EXC_UNDEF};
		bmrf_mode_t m[6] = '{MODE_SVC, MODE_FIQ, MODE_IRQ, MODE_ABT, MODE_ABT, MODE_UND};
		for (int j = 0; j < 6; j++) begin
			i_dp.exc(k[j], 32'h0, 32'h0);
			chk("kind", ctl.mode, m[j]);
			i_dp.ret();
		end
		$display("test kinds done");
	endtask
	task automatic t_flags();
		i_dp.wr(4'hE, 4'h1, 32'h55, {1'b1, 4'b0100, 1'b0, 1'b1});
		chk("zero", liveStatusWord[31:28], 4'h4);
		chk("lanes", liveStatusWord[19:16], 4'h4);
		chk("pass", condPass, 1'b1);
		i_dp.wr(4'hE, 4'h1, 32'h66, {1'b0, 4'b1011, 2'b00});
		chk("noset", ctl.nzcv, 4'h4);
		i_dp.wr(4'h1, 4'h1, 32'h77, {1'b1, 4'b0000, 2'b00});
		chk("fail", ctl.nzcv, 4'h4);
		rd(4'h1, 4'h1);
		chk("r1", rdDataA, 32'h66);
		i_dp.wr(4'hE, 4'h2, 32'h0, 7'b0000010);
		i_dp.wr(4'hE, 4'h2, 32'h0, 7'b0000000);
		chk("sat", ctl.sat, 1'b1);
		i_dp.psw(liveStatusWord & 32'hF7FFFFFF);
		chk("satclr", ctl.sat, 1'b0);
		$display("test flags done");
	endtask
	task automatic t_psw();
		i_dp.psw(32'h05000633);
		chk("compact", ctl.compactIsa, 1'b1);
		chk("bytecode", ctl.bytecode, 1'b1);
		chk("endian", ctl.bigEndian, 1'b1);
		chk("cond", ctl.condBlockState, 8'h06);
		chk("masks", {ctl.abortHeld, ctl.irqBlocked, ctl.fiqBlocked}, 3'h0);
		chk("nopass", condPass, 1'b0);
		i_dp.psw(32'h000001D5);
		chk("bad", ctl.mode, MODE_SVC);
		i_dp.psw(32'h000001DF);
		chk("sys", ctl.mode, MODE_SYS);
		i_dp.wr(4'hE, 4'hD, 32'h99, 7'h00);
		i_dp.psw(32'h000001D0);
		rd(4'hD, 4'h0);
		chk("r13usr", rdDataA, 32'h99);
		i_dp.psw(32'h00000013);
		chk("user", liveStatusWord[8:0], 9'h1D0);
		chk("nosave", savedStatusWord, 32'h0);
		i_dp.exc(EXC_SVC, 32'h0, 32'h8);
		chk("svc", ctl.mode, MODE_SVC);
		$display("test psw done");
	endtask
	initial begin
		repeat (16) @(posedge core_clk);
		rst <= 1'b0;
		#1;
		chk("reset", liveStatusWord, 32'h000001D3);
		t_bank();
		t_kinds();
		t_flags();
		t_psw();
		report_and_stop();
	end
endmodule // bmrf_regfile_test
bind bmrf_regfile bmrf_regfile_props i_props (.core_clk, .rst, .wrReq, .condPass, .pswReq,
	.excReq, .excReturn, .liveStatusWord, .savedStatusWord, .ctl);
